//--- pioc_chk.sv
`timescale 1ns/1ps
module pioc_chk (
   input  wire logic        clk,        // Clock
   input  wire logic        srst,       // Reset
   input  wire logic        reg_wr,     // Write
   input  wire logic        reg_rd,     // Read
   input  wire logic [3:0]  reg_idx,    // Index
   input  wire logic [1:0]  reg_op,     // Op
   input  wire logic [15:0] reg_wdata,  // Wdata
   input  wire logic [15:0] reg_rdata,  // Rdata
   input  wire logic        reg_rvalid, // Rvalid
   input  wire logic [15:0] pin_oe,     // Drive
   input  wire logic [15:0] pullup_on,  // Pull-up
   input  wire logic [15:0] analog_on,  // Analog
   input  wire logic        change_irq  // Irq
);
   import pioc_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   ////////////////////////////////////////
   chk_rd_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   chk_valid_cause: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("stray read valid");
   chk_alias_rd_zero: assert property (reg_rd && reg_op != OP_WRITE |=> reg_rdata == 0)
      else $error("alias read not zero");
   chk_unmapped_zero: assert property (reg_rd && reg_idx > REG_CNSTAT |=> reg_rdata == 0)
      else $error("unmapped read not zero");
   chk_reset_state: assert property ($fell(srst) |-> pin_oe == 0 && analog_on == RST_ANALOG
      && !change_irq) else $error("bad state after reset");
   chk_dir_input: assert property (reg_wr && reg_idx == REG_DIR && reg_op == OP_WRITE
      |-> ##2 (pin_oe & $past(reg_wdata, 2)) == 0) else $error("input pin driven");
   chk_pullup_copy: assert property (reg_wr && reg_idx == REG_PULLUP && reg_op == OP_WRITE
      |-> ##2 pullup_on == $past(reg_wdata, 2)) else $error("pull-up mismatch");
   chk_analog_zero: assert property (reg_rvalid && $past(reg_idx) == REG_LEVEL && !$past(reg_wr)
      |-> (reg_rdata & analog_on) == 0) else $error("analog pin read high");
endmodule : pioc_chk
bind pioc_port pioc_chk u_chk (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_idx(reg_idx), .reg_op(reg_op), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .pin_oe(pin_oe), .pullup_on(pullup_on), .analog_on(analog_on),
   .change_irq(change_irq));

//--- pioc_pins.sv
`timescale 1ns/1ps
module pioc_pins (
   input  wire logic        clk,         // Clock
   input  wire logic [15:0] pin_out,     // Port drive value
   input  wire logic [15:0] pin_oe,      // Port drive enable
   input  wire logic [15:0] pullup_on,   // Weak pull-up
   input  wire logic [15:0] pulldown_on, // Weak pull-down
   input  wire logic [15:0] ext_val,     // Outside drive value
   input  wire logic [15:0] ext_en,      // Outside drive enable
   output logic      [15:0] pin_in       // Wire level
);
   logic [15:0] flt = 16'h0000;
   // Undriven, unpulled lines wander each cycle
   always @(posedge clk)
      flt <= ~pin_in;
   // Port wins, then outside drive, then pulls
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pullup_on | (~pulldown_on & flt)));
endmodule : pioc_pins

//--- pioc_pkg.sv
package pioc_pkg;
   localparam int          PIOC_W          = 16;
   localparam int          PIOC_AW         = 4;
   localparam int          PIOC_NREG       = 10;
   // Register indices
   localparam logic [3:0]  REG_ANALOG      = 4'h0;
   localparam logic [3:0]  REG_DIR         = 4'h1;
   localparam logic [3:0]  REG_LEVEL       = 4'h2;
   localparam logic [3:0]  REG_LATCH       = 4'h3;
   localparam logic [3:0]  REG_ODRAIN      = 4'h4;
   localparam logic [3:0]  REG_PULLUP      = 4'h5;
   localparam logic [3:0]  REG_PULLDN      = 4'h6;
   localparam logic [3:0]  REG_CNCTRL      = 4'h7;
   localparam logic [3:0]  REG_CNEN        = 4'h8;
   localparam logic [3:0]  REG_CNSTAT      = 4'h9;
   // Write operation codes
   localparam logic [1:0]  OP_WRITE        = 2'h0;
   localparam logic [1:0]  OP_CLEAR        = 2'h1;
   localparam logic [1:0]  OP_SET          = 2'h2;
   localparam logic [1:0]  OP_INVERT       = 2'h3;
   // Control field positions
   localparam int          CNCTRL_ON_BIT   = 15;
   localparam int          CNCTRL_SIDL_BIT = 13;
   // Reset values and control write mask
   localparam logic [15:0] RST_ANALOG      = 16'hffff;
   localparam logic [15:0] RST_DIR         = 16'hffff;
   localparam logic [15:0] RST_ZERO        = 16'h0000;
   localparam logic [15:0] CNCTRL_MASK     = 16'ha000;
endpackage : pioc_pkg

//--- pioc_port.sv
`timescale 1ns/1ps
module pioc_port (
   input  wire logic                          clk,           // Clock
   input  wire logic                          srst,          // Sync reset
   input  wire logic                          reg_wr,        // Write strobe
   input  wire logic                          reg_rd,        // Read strobe
   input  wire logic [3:0]                    reg_idx,       // Register index
   input  wire logic [1:0]                    reg_op,        // Write/clear/set/invert
   input  wire logic [pioc_pkg::PIOC_W-1:0]   reg_wdata,     // Write data
   output logic      [pioc_pkg::PIOC_W-1:0]   reg_rdata,     // Read data
   output logic                               reg_rvalid,    // Read data valid
   input  wire logic [pioc_pkg::PIOC_W-1:0]   pin_in,        // Pin levels
   output logic      [pioc_pkg::PIOC_W-1:0]   pin_out,       // Pin drive value
   output logic      [pioc_pkg::PIOC_W-1:0]   pin_oe,        // Pin drive enable
   output logic      [pioc_pkg::PIOC_W-1:0]   pullup_on,     // Weak pull-up on
   output logic      [pioc_pkg::PIOC_W-1:0]   pulldown_on,   // Weak pull-down on
   output logic      [pioc_pkg::PIOC_W-1:0]   analog_on,     // Analog mode
   output logic                               change_irq     // Change interrupt request
);
   import pioc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [PIOC_W-1:0] analog_select;
   logic [PIOC_W-1:0] pin_direction;
   logic [PIOC_W-1:0] output_latch;
   logic [PIOC_W-1:0] open_drain_select;
   logic [PIOC_W-1:0] pullup_enable;
   logic [PIOC_W-1:0] pulldown_enable;
   logic [PIOC_W-1:0] change_notice_control;
   logic [PIOC_W-1:0] change_irq_enable;
   logic [PIOC_W-1:0] change_status;
   logic [PIOC_W-1:0] level_seen;
   logic [PIOC_W-1:0] pin_sync;
   logic [PIOC_W-1:0] pin_level;

   logic [PIOC_W-1:0] next_analog_select;
   logic [PIOC_W-1:0] next_pin_direction;
   logic [PIOC_W-1:0] next_output_latch;
   logic [PIOC_W-1:0] next_open_drain_select;
   logic [PIOC_W-1:0] next_pullup_enable;
   logic [PIOC_W-1:0] next_pulldown_enable;
   logic [PIOC_W-1:0] next_change_notice_control;
   logic [PIOC_W-1:0] next_change_irq_enable;
   logic [PIOC_W-1:0] next_change_status;
   logic [PIOC_W-1:0] next_level_seen;
   logic [PIOC_W-1:0] next_reg_rdata;
   logic              next_reg_rvalid;
   logic [PIOC_W-1:0] next_pin_out;
   logic [PIOC_W-1:0] next_pin_oe;
   logic              next_change_irq;
   logic [PIOC_W-1:0] changed;
   logic              cn_on;
   logic              level_read;
   logic [PIOC_W-1:0] next_pullup_on;
   logic [PIOC_W-1:0] next_pulldown_on;
   logic [PIOC_W-1:0] next_analog_on;

   // One write strobe per mapped register
   logic [PIOC_NREG-1:0] wr_hit;

   // Applies a plain, clear, set or invert write
   function automatic logic [PIOC_W-1:0] apply_op(input logic [PIOC_W-1:0] cur,
                                                  input logic [1:0]        op,
                                                  input logic [PIOC_W-1:0] val);
      logic [PIOC_W-1:0] res;
      res = cur;
      case (op)
         OP_WRITE:  res = val;
         OP_CLEAR:  res = cur & ~val;
         OP_SET:    res = cur | val;
         OP_INVERT: res = cur ^ val;
         default:   res = cur;
      endcase
      return res;
   endfunction : apply_op

   // True for a write strobe to the given index
   function automatic logic hit(input logic       wr,
                                input logic [3:0] idx,
                                input logic [3:0] target);
      return wr && (idx == target);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchroniser
   pioc_sync u_sync (
      .clk  (clk),
      .srst (srst),
      .d    (pin_in),
      .q    (pin_sync)
   );

   // Analog inputs read as low
   assign pin_level  = pin_sync & ~analog_select;
   assign cn_on      = change_notice_control[CNCTRL_ON_BIT];
   assign level_read = reg_rd && (reg_idx == REG_LEVEL);

   // Pin edge against the level one cycle earlier
   assign changed = (pin_level ^ level_seen) & {PIOC_W{cn_on}};

   ////////////////////////////////////////////////////////////////////////////
   // Write decode
   genvar r;
   generate
      for (r = 0; r < PIOC_NREG; r++) begin : g_hit
         assign wr_hit[r] = hit(reg_wr, reg_idx, 4'(r));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Pin control registers
   always_comb begin
      next_analog_select     = analog_select;
      next_pin_direction     = pin_direction;
      next_output_latch      = output_latch;
      next_open_drain_select = open_drain_select;
      next_pullup_enable     = pullup_enable;
      next_pulldown_enable   = pulldown_enable;
      if (wr_hit[REG_ANALOG]) begin
         next_analog_select = apply_op(analog_select, reg_op, reg_wdata);
      end
      if (wr_hit[REG_DIR]) begin
         next_pin_direction = apply_op(pin_direction, reg_op, reg_wdata);
      end
      // Level writes land in the latch
      if (wr_hit[REG_LATCH] || wr_hit[REG_LEVEL]) begin
         next_output_latch = apply_op(output_latch, reg_op, reg_wdata);
      end
      if (wr_hit[REG_ODRAIN]) begin
         next_open_drain_select = apply_op(open_drain_select, reg_op, reg_wdata);
      end
      if (wr_hit[REG_PULLUP]) begin
         next_pullup_enable = apply_op(pullup_enable, reg_op, reg_wdata);
      end
      if (wr_hit[REG_PULLDN]) begin
         next_pulldown_enable = apply_op(pulldown_enable, reg_op, reg_wdata);
      end
      if (srst) begin
         next_analog_select     = RST_ANALOG;
         next_pin_direction     = RST_DIR;
         next_output_latch      = RST_ZERO;
         next_open_drain_select = RST_ZERO;
         next_pullup_enable     = RST_ZERO;
         next_pulldown_enable   = RST_ZERO;
      end
   end

   always_ff @(posedge clk) begin
      analog_select     <= next_analog_select;
      pin_direction     <= next_pin_direction;
      output_latch      <= next_output_latch;
      open_drain_select <= next_open_drain_select;
      pullup_enable     <= next_pullup_enable;
      pulldown_enable   <= next_pulldown_enable;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Change notification control registers
   always_comb begin
      next_change_notice_control = change_notice_control;
      next_change_irq_enable     = change_irq_enable;
      if (wr_hit[REG_CNCTRL]) begin
         next_change_notice_control = apply_op(change_notice_control, reg_op, reg_wdata)
                                      & CNCTRL_MASK;
      end
      if (wr_hit[REG_CNEN]) begin
         next_change_irq_enable = apply_op(change_irq_enable, reg_op, reg_wdata);
      end
      if (srst) begin
         next_change_notice_control = RST_ZERO;
         next_change_irq_enable     = RST_ZERO;
      end
   end

   always_ff @(posedge clk) begin
      change_notice_control <= next_change_notice_control;
      change_irq_enable     <= next_change_irq_enable;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Change status; a level read clears it, a new edge wins
   always_comb begin
      next_level_seen    = pin_level;
      next_change_status = change_status;
      if (level_read) begin
         next_change_status = RST_ZERO;
      end
      // Set wins over the clear
      next_change_status = next_change_status | changed;
      if (srst) begin
         next_change_status = RST_ZERO;
         next_level_seen    = RST_ZERO;
      end
   end

   always_ff @(posedge clk) begin
      change_status <= next_change_status;
      level_seen    <= next_level_seen;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port, one cycle latency
   always_comb begin
      next_reg_rvalid = reg_rd && !srst;
      next_reg_rdata  = RST_ZERO;
      if (reg_rd && !srst) begin
         // Companion reads give zero
         if (reg_op != OP_WRITE) begin
            next_reg_rdata = RST_ZERO;
         end else begin
            case (reg_idx)
               REG_ANALOG: next_reg_rdata = analog_select;
               REG_DIR:    next_reg_rdata = pin_direction;
               REG_LEVEL:  next_reg_rdata = pin_level;
               REG_LATCH:  next_reg_rdata = output_latch;
               REG_ODRAIN: next_reg_rdata = open_drain_select;
               REG_PULLUP: next_reg_rdata = pullup_enable;
               REG_PULLDN: next_reg_rdata = pulldown_enable;
               REG_CNCTRL: next_reg_rdata = change_notice_control;
               REG_CNEN:   next_reg_rdata = change_irq_enable;
               REG_CNSTAT: next_reg_rdata = change_status;
               default:    next_reg_rdata = RST_ZERO;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      reg_rdata  <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers
   genvar g;
   generate
      for (g = 0; g < PIOC_W; g++) begin : g_pin
         always_comb begin
            // Reset releases every pin
            if (srst) begin
               next_pin_oe[g]  = 1'b0;
               next_pin_out[g] = 1'b0;
            end else if (pin_direction[g]) begin
               next_pin_oe[g]  = 1'b0;
               next_pin_out[g] = 1'b0;
            end else if (open_drain_select[g]) begin
               next_pin_oe[g]  = ~output_latch[g];
               next_pin_out[g] = 1'b0;
            end else begin
               next_pin_oe[g]  = 1'b1;
               next_pin_out[g] = output_latch[g];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Output registers; pull, analog and irq reset values forced here, pin reset in the pin drivers
   always_comb begin
      next_pullup_on   = pullup_enable;
      next_pulldown_on = pulldown_enable;
      next_analog_on   = analog_select;
      // Interrupt from enabled status bits
      next_change_irq  = |(change_status & change_irq_enable);
      if (srst) begin
         next_pullup_on   = RST_ZERO;
         next_pulldown_on = RST_ZERO;
         next_analog_on   = RST_ANALOG;
         next_change_irq  = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      pin_out     <= next_pin_out;
      pin_oe      <= next_pin_oe;
      pullup_on   <= next_pullup_on;
      pulldown_on <= next_pulldown_on;
      analog_on   <= next_analog_on;
      change_irq  <= next_change_irq;
   end
endmodule : pioc_port

//--- pioc_sync.sv
`timescale 1ns/1ps
module pioc_sync (
   input  wire logic                      clk,   // Clock
   input  wire logic                      srst,  // Sync reset
   input  wire logic [pioc_pkg::PIOC_W-1:0] d,   // Async pins
   output logic      [pioc_pkg::PIOC_W-1:0] q    // Synced pins
);
   import pioc_pkg::*;
   logic [PIOC_W-1:0] meta;
   logic [PIOC_W-1:0] next_meta;
   logic [PIOC_W-1:0] next_q;

   always_comb begin
      next_meta = srst ? RST_ZERO : d;
      next_q    = srst ? RST_ZERO : meta;
   end

   always_ff @(posedge clk) begin
      meta <= next_meta;
      q    <= next_q;
   end
endmodule : pioc_sync

//--- tb_parallel_io_port_with_change_notice.sv
`timescale 1ns/1ps
module tb_parallel_io_port_with_change_notice;
   import pioc_pkg::*;
   logic        clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, reg_rvalid, change_irq;
   logic [3:0]  reg_idx = 0;
   logic [1:0]  reg_op = 0;
   logic [15:0] reg_wdata = 0, ext_val = 0, ext_en = 16'hffff, v, m, e;
   logic [15:0] reg_rdata, pin_in, pin_out, pin_oe, pullup_on, pulldown_on, analog_on;
   logic [15:0] expq[$];
   int          mismatches = 0, checks_done = 0, seed = 84;
   always #2 clk = ~clk;
   pioc_port dut (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx),
      .reg_op(reg_op), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
      .pulldown_on(pulldown_on), .analog_on(analog_on), .change_irq(change_irq));
   pioc_pins u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
      .pulldown_on(pulldown_on), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
   ////////////////////////////////////////
   task check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task bus(input logic w, input logic r, input logic [3:0] i, input logic [1:0] o,
            input logic [15:0] d);
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= r;
      reg_idx <= i;
      reg_op <= o;
      reg_wdata <= d;
   endtask : bus
   task wr(input logic [3:0] i, input logic [1:0] o, input logic [15:0] d);
      bus(1'b1, 1'b0, i, o, d);
   endtask : wr
   task rd(input logic [3:0] i, input logic [1:0] o, input logic [15:0] x);
      expq.push_back(x);
      bus(1'b0, 1'b1, i, o, 16'h0000);
   endtask : rd
   task idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 4'h0, OP_WRITE, 16'h0000);
   endtask : idle
   task end_sim;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////
   always @(posedge clk) begin
      if (reg_rvalid === 1'b1) begin
         if (expq.size() == 0)
            check({15'h0000, reg_rvalid}, 16'h0000);
         else
            check(reg_rdata, expq.pop_front());
      end
   end
   initial begin
      #40000;
      mismatches++;
      end_sim;
   end
   initial begin
      repeat (5) @(posedge clk);
      srst <= 0;
      check(pin_oe, 16'h0000);
      check(analog_on, RST_ANALOG);
      rd(REG_DIR, OP_WRITE, RST_DIR);
      rd(REG_ANALOG, OP_WRITE, RST_ANALOG);
      for (int i = 10; i < 16; i++) begin
         wr(4'(i), OP_WRITE, 16'hffff);
         rd(4'(i), OP_WRITE, 16'h0000);
      end
      rd(REG_DIR, OP_SET, 16'h0000);
      wr(REG_ANALOG, OP_WRITE, 16'h0000);
      v = 16'($random(seed));
      wr(REG_LATCH, OP_WRITE, v);
      idle(1);
      rd(REG_LATCH, OP_WRITE, v);
      for (int o = 1; o < 4; o++) begin
         m = 16'($random(seed));
         wr(REG_LATCH, 2'(o), m);
         v = (o == 1) ? v & ~m : (o == 2) ? v | m : v ^ m;
         idle(1);
         rd(REG_LATCH, OP_WRITE, v);
      end
      v = 16'($random(seed));
      wr(REG_LEVEL, OP_WRITE, v);
      wr(REG_DIR, OP_WRITE, 16'h0000);
      idle(3);
      check(pin_oe, 16'hffff);
      check(pin_out, v);
      idle(2);
      rd(REG_LEVEL, OP_WRITE, v);
      ext_en <= 16'h0000;
      wr(REG_PULLUP, OP_WRITE, 16'hffff);
      wr(REG_ODRAIN, OP_WRITE, 16'hffff);
      idle(3);
      check(pin_oe, ~v);
      check(pin_out & pin_oe, 16'h0000);
      check(pin_in, v);
      check(pullup_on, 16'hffff);
      m = 16'($random(seed));
      wr(REG_PULLDN, OP_WRITE, m);
      idle(3);
      check(pulldown_on, m);
      e = 16'($random(seed));
      m = 16'($random(seed));
      ext_en <= 16'hffff;
      ext_val <= e;
      wr(REG_ODRAIN, OP_WRITE, 16'h0000);
      wr(REG_PULLUP, OP_WRITE, 16'h0000);
      wr(REG_PULLDN, OP_WRITE, 16'h0000);
      wr(REG_DIR, OP_WRITE, 16'hffff);
      wr(REG_ANALOG, OP_WRITE, m);
      idle(4);
      rd(REG_LEVEL, OP_WRITE, e & ~m);
      wr(REG_ANALOG, OP_WRITE, 16'h0000);
      wr(REG_CNCTRL, OP_WRITE, 16'hffff);
      wr(REG_CNEN, OP_WRITE, 16'h0001);
      idle(1);
      rd(REG_CNCTRL, OP_WRITE, CNCTRL_MASK);
      rd(REG_LEVEL, OP_WRITE, e);
      idle(4);
      ext_val <= e ^ 16'h0002;
      idle(6);
      check({15'h0000, change_irq}, 16'h0000);
      rd(REG_CNSTAT, OP_WRITE, 16'h0002);
      ext_val <= e ^ 16'h0003;
      idle(6);
      check({15'h0000, change_irq}, 16'h0001);
      rd(REG_LEVEL, OP_WRITE, e ^ 16'h0003);
      idle(4);
      check({15'h0000, change_irq}, 16'h0000);
      rd(REG_CNSTAT, OP_WRITE, 16'h0000);
      idle(3);
      end_sim;
   end
endmodule : tb_parallel_io_port_with_change_notice
